// *** shunt_adc_b_config_regs.sv ***
// Purpose: Configuration registers and conversion sequencing of the second shunt converter
// Assumes: Modulator samples, standby and power-down arrive on clk
// Notes: Modulator rate is clk divided by MOD_DIV
//
// Operation
// - Bit 11 selects continuous or single-shot
// - Oversampling codes map to ratios 64..8192
// - Data rate is modulator rate over ratio, or over ratio plus chop delay with chop on
// - Bit 3 enables global chop, resets off
// - Chop delay 000 is 2, 001 is 4
// - Bit 15 enables channel, resets on
// - Disable or low power clears result, counter
// - Gain codes select 4, 8, 16, 32
// - Gains 16, 32 use analog 8 plus digital
// - Mux normal, swapped, shorted, or test DAC
// - Bit 5 routes source to positive/negative input
// - Bit 4 routes sink, resets to negative
// - Source level off, 4, 40, 240 uA
// - Sink level off, 4, 40, 240 uA
// - Reserved bits read zero, ignore writes
// - Offset C4h holds calibration bits 23:8
// - Calibration word applied as signed value
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "shunt_adc_b_map.svh"

module shunt_adc_b_config_regs import shunt_adc_b_pkg::*; #(
    parameter int MOD_DIV = `MOD_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic standby,
    input wire logic power_down,
    input wire logic [23:0] raw_sample,
    output logic modulator_tick,
    output logic data_ready,
    output logic [23:0] conversion_result,
    output logic [1:0] conversion_counter,
    output logic busy,
    output logic chop_phase,
    output logic conversion_mode_select,
    output logic [13:0] oversampling_ratio,
    output logic global_chop_enable,
    output logic [8:0] global_chop_delay,
    output logic channel_enable,
    output logic analog_gain_x8,
    output logic input_mux_normal,
    output logic input_mux_swapped,
    output logic input_short_to_ground,
    output logic input_test_dac,
    output logic open_wire_source_route,
    output logic open_wire_sink_route,
    output logic [1:0] open_wire_source_level,
    output logic [1:0] open_wire_sink_level
);

    // ============================================================
    // Shared decode
    function automatic logic [13:0] scaled_periods(input logic [13:0] base, input logic [2:0] code);
        scaled_periods = base << code;
    endfunction

    // ============================================================
    // Gain decode
    function automatic logic [1:0] digital_shift(input logic [1:0] code);
        if (code == GAIN_X16) begin
            digital_shift = 2'h1;
        end else if (code == GAIN_X32) begin
            digital_shift = 2'h2;
        end else begin
            digital_shift = 2'h0;
        end
    endfunction

    localparam int DIV_W = (MOD_DIV > 1) ? $clog2(MOD_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MOD_DIV - 1);

    // ============================================================
    // Register storage
    logic [15:0] conv_cfg;
    logic [15:0] input_cfg;
    logic [15:0] offset_cal_high;
    logic start_pending;
    conv_state_e state;
    logic [13:0] period_count;
    logic [DIV_W-1:0] div_count;

    wire hit_conv_cfg = (addr == `ADDR_CONV_CFG);
    wire hit_input_cfg = (addr == `ADDR_INPUT_CFG);
    wire hit_offset = (addr == `ADDR_OFFSET_CAL_HIGH);
    wire hit_ctrl = (addr == `ADDR_CONV_CTRL);
    wire hit_status = (addr == `ADDR_CONV_STATUS);
    wire hit_res_high = (addr == `ADDR_RESULT_HIGH);
    wire hit_res_low = (addr == `ADDR_RESULT_LOW);

    // Writable bits only; reserved positions stay zero
    wire [15:0] conv_cfg_mask = `MASK_CONV_CFG;
    wire [15:0] input_cfg_mask = `MASK_INPUT_CFG;

    // ============================================================
    // Field decode
    wire [2:0] osr_code = conv_cfg[`POS_OSR_HI:`POS_OSR_LO];
    wire [2:0] gc_delay_code = conv_cfg[`POS_GC_DELAY_HI:`POS_GC_DELAY_LO];
    wire [1:0] gain_code = input_cfg[`POS_GAIN_HI:`POS_GAIN_LO];
    wire [1:0] mux_code = input_cfg[`POS_MUX_HI:`POS_MUX_LO];
    wire [13:0] osr_periods = scaled_periods(`OSR_BASE, osr_code);
    wire [13:0] gc_periods = scaled_periods(`GC_DELAY_BASE, gc_delay_code);
    wire single_shot = conv_cfg[`POS_CONV_MODE];
    wire gc_on = conv_cfg[`POS_GC_EN];
    wire ch_on = input_cfg[`POS_CH_EN];
    wire active = ch_on & ~standby & ~power_down;

    assign conversion_mode_select = single_shot;
    assign oversampling_ratio = osr_periods;
    assign global_chop_enable = gc_on;
    assign global_chop_delay = gc_periods[8:0];
    assign channel_enable = ch_on;
    assign analog_gain_x8 = (gain_code != GAIN_X4);
    wire [3:0] mux_onehot;

    for (genvar m = 0; m < 4; m++) begin : g_mux_decode
        assign mux_onehot[m] = (mux_code == 2'(m));
    end

    assign input_mux_normal = mux_onehot[MUX_NORMAL];
    assign input_mux_swapped = mux_onehot[MUX_SWAPPED];
    assign input_short_to_ground = mux_onehot[MUX_SHORTED];
    assign input_test_dac = mux_onehot[MUX_TEST_DAC];
    assign open_wire_source_route = input_cfg[`POS_SRC_ROUTE];
    assign open_wire_sink_route = input_cfg[`POS_SINK_ROUTE];
    assign open_wire_source_level = input_cfg[`POS_SRC_LVL_HI:`POS_SRC_LVL_LO];
    assign open_wire_sink_level = input_cfg[`POS_SINK_LVL_HI:`POS_SINK_LVL_LO];

    // ============================================================
    // Register writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_cfg <= `RST_CONV_CFG;
            input_cfg <= `RST_INPUT_CFG;
            offset_cal_high <= `RST_OFFSET_CAL_HIGH;
        end else if (wr) begin
            if (hit_conv_cfg) begin
                conv_cfg <= wdata & conv_cfg_mask;
            end
            if (hit_input_cfg) begin
                input_cfg <= wdata & input_cfg_mask;
            end
            if (hit_offset) begin
                offset_cal_high <= wdata;
            end
        end
    end

    // ============================================================
    // Modulator clock enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_count <= '0;
        end else if (div_count == DIV_LAST) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + DIV_W'(1);
        end
    end

    assign modulator_tick = (div_count == DIV_LAST);

    // ============================================================
    // Result scaling and offset
    wire [1:0] dig_shift = digital_shift(gain_code);
    wire [26:0] raw_ext = {{3{raw_sample[23]}}, raw_sample};
    wire [26:0] scaled = raw_ext << dig_shift;
    wire [26:0] offset_ext = {{3{offset_cal_high[15]}}, offset_cal_high, 8'h00};
    wire [26:0] sum = scaled + offset_ext;
    wire in_range = (sum[26:23] == 4'h0) || (sum[26:23] == 4'hf);
    wire [23:0] saturated = in_range ? sum[23:0] : (sum[26] ? 24'h800000 : 24'h7fffff);

    // ============================================================
    // Conversion sequencer
    wire start_write = wr & hit_ctrl & wdata[`POS_START];
    wire count_done = modulator_tick && (period_count == 14'h0001);
    wire conv_done = (state == ST_CONVERT) && count_done;
    wire may_start = active && (!single_shot || start_pending);

    conv_state_e next_state;
    logic [13:0] next_period_count;

    always_comb begin
        next_state = state;
        next_period_count = period_count;
        if (!active) begin
            next_state = ST_IDLE;
            next_period_count = 14'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (may_start) begin
                        next_state = gc_on ? ST_SETTLE : ST_CONVERT;
                        next_period_count = gc_on ? gc_periods : osr_periods;
                    end
                end
                ST_SETTLE: begin
                    if (count_done) begin
                        next_state = ST_CONVERT;
                        next_period_count = osr_periods;
                    end else if (modulator_tick) begin
                        next_period_count = period_count - 14'h0001;
                    end
                end
                ST_CONVERT: begin
                    if (count_done) begin
                        if (single_shot) begin
                            next_state = ST_IDLE;
                            next_period_count = 14'h0000;
                        end else begin
                            next_state = gc_on ? ST_SETTLE : ST_CONVERT;
                            next_period_count = gc_on ? gc_periods : osr_periods;
                        end
                    end else if (modulator_tick) begin
                        next_period_count = period_count - 14'h0001;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                    next_period_count = 14'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            period_count <= 14'h0000;
        end else begin
            state <= next_state;
            period_count <= next_period_count;
        end
    end

    // Start request survives until a conversion begins; a new request wins over the clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start_pending <= 1'b0;
        end else if (start_write) begin
            start_pending <= 1'b1;
        end else if ((state == ST_IDLE) && may_start) begin
            start_pending <= 1'b0;
        end
    end

    assign busy = (state != ST_IDLE);

    // ============================================================
    // Result, counter and chop phase
    always_ff @(posedge clk) begin
        if (sys_rst || !active) begin
            conversion_result <= 24'h000000;
            conversion_counter <= 2'b00;
            chop_phase <= 1'b0;
            data_ready <= 1'b0;
        end else begin
            data_ready <= conv_done;
            if (conv_done) begin
                conversion_result <= saturated;
                conversion_counter <= conversion_counter + 2'b01;
                chop_phase <= gc_on ? ~chop_phase : 1'b0;
            end
        end
    end

    // ============================================================
    // Register reads
    wire [15:0] status_word = {12'h000, busy, chop_phase, conversion_counter};
    logic [15:0] read_mux;

    always_comb begin
        read_mux = 16'h0000;
        if (hit_conv_cfg) begin
            read_mux = conv_cfg;
        end else if (hit_input_cfg) begin
            read_mux = input_cfg;
        end else if (hit_offset) begin
            read_mux = offset_cal_high;
        end else if (hit_status) begin
            read_mux = status_word;
        end else if (hit_res_high) begin
            read_mux = conversion_result[23:8];
        end else if (hit_res_low) begin
            read_mux = {conversion_result[7:0], 8'h00};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rd ? read_mux : 16'h0000;
        end
    end

endmodule // shunt_adc_b_config_regs

// *** shunt_adc_b_config_regs_properties.sv ***
// Purpose: Port-level checks of the second shunt converter block
// Assumes: Bound to every instance of shunt_adc_b_config_regs
// Notes: Reset disables every property
`timescale 1ns/100ps
`include "shunt_adc_b_map.svh"
module shunt_adc_b_config_regs_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic standby,
    input wire logic power_down,
    input wire logic data_ready,
    input wire logic [23:0] conversion_result,
    input wire logic [1:0] conversion_counter,
    input wire logic conversion_mode_select,
    input wire logic [13:0] oversampling_ratio,
    input wire logic global_chop_enable,
    input wire logic [8:0] global_chop_delay,
    input wire logic channel_enable,
    input wire logic analog_gain_x8,
    input wire logic input_mux_normal,
    input wire logic input_mux_swapped,
    input wire logic input_short_to_ground,
    input wire logic input_test_dac,
    input wire logic open_wire_source_route,
    input wire logic open_wire_sink_route,
    input wire logic [1:0] open_wire_source_level,
    input wire logic [1:0] open_wire_sink_level
);
    // ============================================================
    // Decode of bus writes
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire wr_conv = wr && addr == `ADDR_CONV_CFG;
    wire wr_input = wr && addr == `ADDR_INPUT_CFG;
    wire off = !channel_enable || standby || power_down;
    wire [3:0] mux_hot = {input_test_dac, input_short_to_ground, input_mux_swapped, input_mux_normal};
    wire [5:0] ow = {open_wire_source_route, open_wire_sink_route, open_wire_source_level, open_wire_sink_level};

    // ============================================================
    // Properties
    property p_mode; wr_conv |=> conversion_mode_select == $past(wdata[11]); endproperty
    property p_osr; wr_conv |=> oversampling_ratio == (14'h0040 << $past(wdata[10:8])); endproperty
    property p_chop; wr_conv |=> global_chop_enable == $past(wdata[3]) && global_chop_delay == (9'h002 << $past(wdata[2:0])); endproperty
    property p_enable; wr_input |=> channel_enable == $past(wdata[15]); endproperty
    property p_clear; off |=> conversion_result == 24'h000000 && conversion_counter == 2'b00 && !data_ready; endproperty
    property p_gain; wr_input |=> analog_gain_x8 == ($past(wdata[11:10]) != 2'b00); endproperty
    property p_mux; wr_input |=> mux_hot == (4'h1 << $past(wdata[9:8])); endproperty
    property p_ow; wr_input |=> ow == $past(wdata[5:0]); endproperty
    property p_rsv; rd && addr == `ADDR_CONV_CFG |=> rdata[15:12] == 4'h0 && rdata[7:4] == 4'h0; endproperty
    a_mode: assert property (p_mode) else $error("mode bit mismatch");
    a_osr: assert property (p_osr) else $error("ratio decode mismatch");
    a_chop: assert property (p_chop) else $error("chop decode mismatch");
    a_enable: assert property (p_enable) else $error("enable bit mismatch");
    a_clear: assert property (p_clear) else $error("result not cleared");
    a_gain: assert property (p_gain) else $error("analog gain mismatch");
    a_mux: assert property (p_mux) else $error("mux decode mismatch");
    a_ow: assert property (p_ow) else $error("open wire mismatch");
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    c_ready: cover property (data_ready);
    c_single: cover property (conversion_mode_select && data_ready);
    c_off: cover property (off && conversion_counter != 2'b00);
endmodule // shunt_adc_b_config_regs_properties
bind shunt_adc_b_config_regs shunt_adc_b_config_regs_properties chk (.*);

// *** shunt_adc_b_map.svh ***
// Purpose: Register offsets, field positions, reset values and counts
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef SHUNT_ADC_B_MAP_SVH
`define SHUNT_ADC_B_MAP_SVH

// ============================================================
// Register offsets
`define ADDR_CONV_CFG 8'hc2
`define ADDR_INPUT_CFG 8'hc3
`define ADDR_OFFSET_CAL_HIGH 8'hc4
`define ADDR_CONV_CTRL 8'hf0
`define ADDR_CONV_STATUS 8'hf1
`define ADDR_RESULT_HIGH 8'hf2
`define ADDR_RESULT_LOW 8'hf3

// ============================================================
// Reset values
`define RST_CONV_CFG 16'h0400
`define RST_INPUT_CFG 16'h8010
`define RST_OFFSET_CAL_HIGH 16'h0000

// ============================================================
// Writable bit masks
`define MASK_CONV_CFG 16'h0f0f
`define MASK_INPUT_CFG 16'h8f3f

// ============================================================
// Conversion configuration fields
`define POS_CONV_MODE 11
`define POS_OSR_HI 10
`define POS_OSR_LO 8
`define POS_GC_EN 3
`define POS_GC_DELAY_HI 2
`define POS_GC_DELAY_LO 0

// ============================================================
// Input configuration fields
`define POS_CH_EN 15
`define POS_GAIN_HI 11
`define POS_GAIN_LO 10
`define POS_MUX_HI 9
`define POS_MUX_LO 8
`define POS_SRC_ROUTE 5
`define POS_SINK_ROUTE 4
`define POS_SRC_LVL_HI 3
`define POS_SRC_LVL_LO 2
`define POS_SINK_LVL_HI 1
`define POS_SINK_LVL_LO 0

// ============================================================
// Control and status fields
`define POS_START 0
`define POS_STAT_BUSY 3
`define POS_STAT_CHOP 2

// ============================================================
// Timing bases in modulator periods, and the default clk divider per modulator period
`define OSR_BASE 14'h0040
`define GC_DELAY_BASE 14'h0002
`define MOD_DIV_DEFAULT 15

`endif

// *** shunt_adc_b_pkg.sv ***
// Purpose: Types for the second shunt converter configuration block
// Assumes: Nothing
// Notes: Constants live in shunt_adc_b_map.svh
package shunt_adc_b_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_e;

    typedef enum logic [1:0] {
        MUX_NORMAL = 2'b00,
        MUX_SWAPPED = 2'b01,
        MUX_SHORTED = 2'b10,
        MUX_TEST_DAC = 2'b11
    } input_mux_e;

    typedef enum logic [1:0] {
        GAIN_X4 = 2'b00,
        GAIN_X8 = 2'b01,
        GAIN_X16 = 2'b10,
        GAIN_X32 = 2'b11
    } gain_e;

endpackage

// *** tb.sv ***
// Purpose: Self-checking bench of the second shunt converter block
// Assumes: Modulator divider shortened to 2
// Notes: Random register traffic plus conversion corner cases
`timescale 1ns/100ps
`include "shunt_adc_b_map.svh"
module tb import shunt_adc_b_pkg::*;;
    localparam int MODDIV = 2;
    logic clk = 0, sys_rst = 1, wr = 0, rd = 0, standby = 0, power_down = 0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [23:0] raw_sample = 24'h000000, conversion_result;
    logic modulator_tick, data_ready, busy, chop_phase, conversion_mode_select, global_chop_enable;
    logic channel_enable, analog_gain_x8, input_mux_normal, input_mux_swapped, input_short_to_ground;
    logic input_test_dac, open_wire_source_route, open_wire_sink_route;
    logic [1:0] conversion_counter, open_wire_source_level, open_wire_sink_level;
    logic [13:0] oversampling_ratio;
    logic [8:0] global_chop_delay;
    int n_errors = 0, compares = 0;

    shunt_adc_b_config_regs #(.MOD_DIV(MODDIV)) dut (.*);

    always #4 clk = ~clk;

    // ============================================================
    // Shared tasks
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task end_of_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_ready(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (n < 4000 && data_ready !== 1'b1);
        check("ready timeout", n < 4000, 1'b1);
    endtask
    function automatic logic [15:0] rmask(input logic [7:0] a);
        return a == `ADDR_CONV_CFG ? 16'h0f0f : a == `ADDR_INPUT_CFG ? 16'h8f3f : 16'hffff;
    endfunction
    function automatic logic [23:0] expect_result(input logic [23:0] raw, input int g, input logic [15:0] cal);
        return 24'(raw << (g > 1 ? g - 1 : 0)) + {cal, 8'h00};
    endfunction

    // ============================================================
    // Scenarios
    initial begin
        logic [15:0] d, q;
        logic [7:0] a;
        logic c;
        logic [23:0] r;
        int n, p;
        void'($urandom(58));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd_reg(8'hc2, q); check("conv cfg reset", q, 16'h0400);
        rd_reg(8'hc3, q); check("input cfg reset", q, 16'h8010);
        rd_reg(8'hc4, q); check("offset reset", q, 16'h0000);
        rd_reg(8'h10, q); check("unmapped read", q, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            a = 8'hc2 + 8'(i % 3);
            d = 16'($urandom);
            d[10:8] = 3'(i / 3);
            d[2:0] = ~d[10:8];
            raw_sample <= 24'($urandom);
            wr_reg(a, d);
            rd_reg(a, q); check("readback", q, d & rmask(a));
            if (a == 8'hc2) check("conv decode", {oversampling_ratio, global_chop_delay, global_chop_enable,
                conversion_mode_select}, {14'h0040 << d[10:8], 9'h002 << d[2:0], d[3], d[11]});
            if (a == 8'hc3) check("input decode", {channel_enable, analog_gain_x8, input_test_dac,
                input_short_to_ground, input_mux_swapped, input_mux_normal, open_wire_source_route,
                open_wire_sink_route, open_wire_source_level, open_wire_sink_level},
                {d[15], d[11:10] != 2'b00, 4'h1 << d[9:8], d[5:0]});
        end
        wr_reg(8'hc4, 16'hfffe);
        raw_sample <= 24'h000345;
        wr_reg(8'hc3, 16'h0010);
        wr_reg(8'hc2, 16'h0000);
        wr_reg(8'hc3, 16'h8010);
        wait_ready(n); wait_ready(n); wait_ready(p);
        check("period", p, 64 * MODDIV);
        for (int g = 0; g < 4; g++) begin
            wr_reg(8'hc3, 16'h8010 | (16'(g) << 10));
            wait_ready(n); wait_ready(n);
            r = expect_result(24'h000345, g, 16'hfffe);
            check("scaled result", conversion_result, r);
            rd_reg(8'hf2, q); check("result high", q, r[23:8]);
            rd_reg(8'hf3, q); check("result low", q, {r[7:0], 8'h00});
        end
        wr_reg(8'hc2, 16'h0009);
        wait_ready(n); wait_ready(n);
        c = chop_phase;
        wait_ready(p);
        check("chop toggle", chop_phase, !c);
        check("chop settle", p, (64 + 4) * MODDIV);
        wr_reg(8'hc2, 16'h0800);
        repeat (300) @(posedge clk);
        wr_reg(8'hf0, 16'h0001);
        wait_ready(n); check("single shot", n < 400, 1'b1);
        n = 0;
        p = 0;
        repeat (1000) begin
            @(posedge clk);
            #1;
            if (data_ready !== 1'b0) n++;
            if (modulator_tick === 1'b1) p++;
        end
        check("single shot stop", n, 0);
        check("tick rate", p, 1000 / MODDIV);
        check("single shot idle", busy, 1'b0);
        rd_reg(8'hf1, q); check("status idle", q[15:2], 14'h0000);
        rd_reg(8'hf0, q); check("control read", q, 16'h0000);
        wr_reg(8'hc2, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            wait_ready(n);
            check("running", busy, 1'b1);
            if (k > 0) check("counter", conversion_counter, 2'h1);
            @(posedge clk);
            standby <= k == 0;
            power_down <= k == 1;
            if (k == 2) wr_reg(8'hc3, 16'h0010);
            repeat (2) @(posedge clk);
            #1 check("cleared", {conversion_result, conversion_counter}, 26'h0);
            standby <= 1'b0;
            power_down <= 1'b0;
            wr_reg(8'hc3, 16'h8010);
        end
        end_of_test();
    end

    initial begin
        #(8 * 60000);
        n_errors++;
        end_of_test();
    end
endmodule // tb
